// ==== rtl/ras_pkg.sv ====
package ras_pkg;

	// ----------------------------------------------------------------
	// Stack geometry.
	// ----------------------------------------------------------------
	localparam int RAS_DEPTH = 31;
	localparam int RAS_PTR_W = 5;
	localparam int RAS_PC_W = 21;
	localparam logic [4:0] RAS_PTR_ZERO = 5'h00;
	localparam logic [4:0] RAS_PTR_ONE = 5'h01;
	localparam logic [4:0] RAS_PTR_LAST = 5'h1F;
	localparam logic [4:0] RAS_PTR_NEAR = 5'h1E;
	localparam logic [20:0] RAS_PC_STEP = 21'h000002;
	localparam logic [20:0] RAS_PC_ZERO = 21'h000000;

	// ----------------------------------------------------------------
	// Program memory vectors.
	// ----------------------------------------------------------------
	localparam logic [20:0] RAS_VEC_RESET = 21'h000000;
	localparam logic [20:0] RAS_VEC_HIGH = 21'h000008;
	localparam logic [20:0] RAS_VEC_LOW = 21'h000018;

	// ----------------------------------------------------------------
	// Register map (byte addresses) and field layout.
	// ----------------------------------------------------------------
	localparam int RAS_ADDR_W = 8;
	localparam logic [7:0] RAS_REG_PTR_STAT = 8'h00;
	localparam logic [7:0] RAS_REG_TOP_UPPER = 8'h04;
	localparam logic [7:0] RAS_REG_TOP_HIGH = 8'h08;
	localparam logic [7:0] RAS_REG_TOP_LOW = 8'h0C;
	localparam logic [7:0] RAS_REG_CONFIG = 8'h10;
	localparam int RAS_BIT_FULL = 7;
	localparam int RAS_BIT_UNF = 6;
	localparam int RAS_BIT_FRE = 0;
	localparam int RAS_UPPER_LSB = 16;
	localparam int RAS_HIGH_LSB = 8;
	localparam logic RAS_FRE_RESET = 1'b1;
	localparam logic [1:0] RAS_RESP_OKAY = 2'h0;
	localparam logic [1:0] RAS_RESP_SLVERR = 2'h2;

	typedef logic [4:0] ras_ptr_t;
	typedef logic [20:0] ras_pc_t;

endpackage

// ==== rtl/ras_return_stack.sv ====
// The AXI4-Lite interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module ras_return_stack (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic core_reset,
	input wire logic call_push,
	input wire logic irq_ack,
	input wire logic irq_high,
	input wire logic push_instr,
	input wire logic return_pop,
	input wire logic pop_instr,
	input wire logic fast_call,
	input wire logic fast_return,
	input wire ras_pkg::ras_pc_t pc_in,
	input wire logic [7:0] status_in,
	input wire logic [7:0] working_register_in,
	input wire logic [7:0] bank_select_register_in,
	output logic pc_load,
	output ras_pkg::ras_pc_t pc_out,
	output logic shadow_restore,
	output logic [7:0] status_out,
	output logic [7:0] working_register_out,
	output logic [7:0] bank_select_register_out,
	output logic fault_reset,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	import ras_pkg::*;

	// ----------------------------------------------------------------
	// State.
	// ----------------------------------------------------------------
	ras_pc_t mem_r [1:RAS_DEPTH];
	ras_ptr_t ptr_r, ptr_nxt, wr_idx;
	logic full_r, unf_r, fre_r;
	logic [7:0] awaddr_r;
	logic aw_have_r, w_have_r, wr_fire;
	logic [31:0] wdata_r, rdata_r;
	logic [3:0] wstrb_r;
	logic [1:0] bresp_r, rresp_r;
	logic bvalid_r, rvalid_r;
	logic pc_load_r, restore_r, fault_r;
	ras_pc_t pc_out_r;
	logic [7:0] status_out_r, working_register_out_r, bsr_out_r;
	logic [7:0] sh_status_r, sh_working_register_r, sh_bsr_r;

	// Sequencer decode.
	logic push_any, pop_any, seq_op;
	logic full_set, unf_set, fault_nxt, stk_we;
	ras_pc_t stk_wdata, top_entry;
	logic sw_ptr_we, sw_cfg_we, sw_up_we, sw_hi_we, sw_lo_we;
	logic clr_full, clr_unf, wr_mapped, rd_mapped;
	logic [31:0] rd_value;

	// ----------------------------------------------------------------
	// Sequencer side: push and pop decisions.
	// ----------------------------------------------------------------
	// Entry selected by the pointer; pointer zero owns no storage.
	assign top_entry = (ptr_r == RAS_PTR_ZERO) ? RAS_PC_ZERO : mem_r[ptr_r];
	assign push_any = call_push | irq_ack | push_instr;
	assign pop_any = return_pop | pop_instr;
	assign seq_op = push_any | pop_any;
	assign wr_idx = ptr_r + RAS_PTR_ONE;

	// Next pointer, flag sets, fault request and stack write.
	always_comb begin
		ptr_nxt = ptr_r;
		full_set = 1'b0;
		unf_set = 1'b0;
		fault_nxt = 1'b0;
		stk_we = 1'b0;
		stk_wdata = pc_in;
		if (push_any) begin
			if (ptr_r == RAS_PTR_LAST) begin
				full_set = 1'b1;
				fault_nxt = fre_r;
			end else begin
				ptr_nxt = ptr_r + RAS_PTR_ONE;
				stk_we = 1'b1;
				if (ptr_r == RAS_PTR_NEAR) begin
					full_set = 1'b1;
					fault_nxt = fre_r;
					if (fre_r) begin
						stk_wdata = pc_in + RAS_PC_STEP;
					end
				end
			end
			if (fault_nxt) begin
				ptr_nxt = RAS_PTR_ZERO;
			end
		end else if (pop_any) begin
			if (ptr_r == RAS_PTR_ZERO) begin
				unf_set = 1'b1;
				fault_nxt = fre_r;
			end else begin
				ptr_nxt = ptr_r - RAS_PTR_ONE;
			end
		end else if (sw_ptr_we) begin
			ptr_nxt = wdata_r[RAS_PTR_W-1:0];
		end
		if (core_reset) begin
			ptr_nxt = RAS_PTR_ZERO;
		end
	end

	// Pointer register, cleared by every reset.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ptr_r <= RAS_PTR_ZERO;
		end else begin
			ptr_r <= ptr_nxt;
		end
	end

	// Sticky flags: only power-on reset or a software zero clears them.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			full_r <= 1'b0;
			unf_r <= 1'b0;
		end else begin
			full_r <= (full_r & ~clr_full) | full_set;
			unf_r <= (unf_r & ~clr_unf) | unf_set;
		end
	end

	// Storage entries; a software edit of the top entry loses to the
	// sequencer, which software must keep quiet during the edit.
	generate
		for (genvar i = 1; i <= RAS_DEPTH; i++) begin : g_entry
			always_ff @(posedge aclk) begin
				if (stk_we && wr_idx == RAS_PTR_W'(i)) begin
					mem_r[i] <= stk_wdata;
				end else if (!seq_op && ptr_r == RAS_PTR_W'(i)) begin
					if (sw_up_we) begin
						mem_r[i][RAS_PC_W-1:RAS_UPPER_LSB] <=
							wdata_r[RAS_PC_W-RAS_UPPER_LSB-1:0];
					end
					if (sw_hi_we) begin
						mem_r[i][RAS_UPPER_LSB-1:RAS_HIGH_LSB] <=
							wdata_r[7:0];
					end
					if (sw_lo_we) begin
						mem_r[i][RAS_HIGH_LSB-1:0] <= wdata_r[7:0];
					end
				end
			end
		end
	endgenerate

	// Program counter load toward the sequencer; the latches are not
	// driven from here at all, so calls and returns leave them alone.
	always_ff @(posedge aclk) begin
		if (!aresetn || core_reset) begin
			pc_load_r <= 1'b0;
			pc_out_r <= RAS_VEC_RESET;
		end else if (irq_ack) begin
			pc_load_r <= 1'b1;
			pc_out_r <= irq_high ? RAS_VEC_HIGH : RAS_VEC_LOW;
		end else if (return_pop && !push_any) begin
			pc_load_r <= 1'b1;
			pc_out_r <= top_entry;
		end else begin
			pc_load_r <= 1'b0;
		end
	end

	// Device reset request on a stack fault.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			fault_r <= 1'b0;
		end else begin
			fault_r <= fault_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Fast register shadow.
	// ----------------------------------------------------------------
	// One-deep hidden copy; the latest vectoring always overwrites it.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sh_status_r <= 8'h00;
			sh_working_register_r <= 8'h00;
			sh_bsr_r <= 8'h00;
		end else if (irq_ack || fast_call) begin
			sh_status_r <= status_in;
			sh_working_register_r <= working_register_in;
			sh_bsr_r <= bank_select_register_in;
		end
	end

	// Restore strobe and values for a fast return.
	always_ff @(posedge aclk) begin
		if (!aresetn || core_reset) begin
			restore_r <= 1'b0;
			status_out_r <= 8'h00;
			working_register_out_r <= 8'h00;
			bsr_out_r <= 8'h00;
		end else begin
			restore_r <= fast_return;
			if (fast_return) begin
				status_out_r <= sh_status_r;
				working_register_out_r <= sh_working_register_r;
				bsr_out_r <= sh_bsr_r;
			end
		end
	end

	// ----------------------------------------------------------------
	// AXI4-Lite slave.
	// ----------------------------------------------------------------
	// Write address and data are captured independently.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_r <= 1'b0;
			awaddr_r <= 8'h00;
			w_have_r <= 1'b0;
			wdata_r <= 32'h00000000;
			wstrb_r <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_r <= 1'b1;
				awaddr_r <= s_axi_awaddr;
			end else if (wr_fire) begin
				aw_have_r <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_r <= 1'b1;
				wdata_r <= s_axi_wdata;
				wstrb_r <= s_axi_wstrb;
			end else if (wr_fire) begin
				w_have_r <= 1'b0;
			end
		end
	end

	assign wr_fire = aw_have_r & w_have_r & ~bvalid_r;
	assign wr_mapped = (awaddr_r == RAS_REG_PTR_STAT) ||
		(awaddr_r == RAS_REG_TOP_UPPER) || (awaddr_r == RAS_REG_TOP_HIGH) ||
		(awaddr_r == RAS_REG_TOP_LOW) || (awaddr_r == RAS_REG_CONFIG);

	// Register write strobes, low byte lane only.
	always_comb begin
		sw_ptr_we = 1'b0;
		sw_cfg_we = 1'b0;
		sw_up_we = 1'b0;
		sw_hi_we = 1'b0;
		sw_lo_we = 1'b0;
		if (wr_fire && wstrb_r[0]) begin
			sw_ptr_we = (awaddr_r == RAS_REG_PTR_STAT);
			sw_cfg_we = (awaddr_r == RAS_REG_CONFIG);
			sw_up_we = (awaddr_r == RAS_REG_TOP_UPPER);
			sw_hi_we = (awaddr_r == RAS_REG_TOP_HIGH);
			sw_lo_we = (awaddr_r == RAS_REG_TOP_LOW);
		end
	end

	assign clr_full = sw_ptr_we & ~wdata_r[RAS_BIT_FULL];
	assign clr_unf = sw_ptr_we & ~wdata_r[RAS_BIT_UNF];

	// Fault reset enable, set out of power-on reset.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			fre_r <= RAS_FRE_RESET;
		end else if (sw_cfg_we) begin
			fre_r <= wdata_r[RAS_BIT_FRE];
		end
	end

	// Write response.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_r <= 1'b0;
			bresp_r <= RAS_RESP_OKAY;
		end else if (wr_fire) begin
			bvalid_r <= 1'b1;
			bresp_r <= wr_mapped ? RAS_RESP_OKAY : RAS_RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_r <= 1'b0;
		end
	end

	// Read value mux; unused bits, bit 5 included, read as zero.
	always_comb begin
		rd_value = 32'h00000000;
		rd_mapped = 1'b1;
		case (s_axi_araddr)
			RAS_REG_PTR_STAT: begin
				rd_value[RAS_BIT_FULL] = full_r;
				rd_value[RAS_BIT_UNF] = unf_r;
				rd_value[RAS_PTR_W-1:0] = ptr_r;
			end
			RAS_REG_TOP_UPPER: begin
				rd_value[RAS_PC_W-RAS_UPPER_LSB-1:0] =
					top_entry[RAS_PC_W-1:RAS_UPPER_LSB];
			end
			RAS_REG_TOP_HIGH: begin
				rd_value[7:0] = top_entry[RAS_UPPER_LSB-1:RAS_HIGH_LSB];
			end
			RAS_REG_TOP_LOW: begin
				rd_value[7:0] = top_entry[RAS_HIGH_LSB-1:0];
			end
			RAS_REG_CONFIG: begin
				rd_value[RAS_BIT_FRE] = fre_r;
			end
			default: begin
				rd_mapped = 1'b0;
			end
		endcase
	end

	// Read data channel.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_r <= 1'b0;
			rdata_r <= 32'h00000000;
			rresp_r <= RAS_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rvalid_r <= 1'b1;
			rdata_r <= rd_value;
			rresp_r <= rd_mapped ? RAS_RESP_OKAY : RAS_RESP_SLVERR;
		end else if (s_axi_rready) begin
			rvalid_r <= 1'b0;
		end
	end

	// Ready flags as registered state.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_arready <= 1'b0;
		end else begin
			s_axi_awready <= ~aw_have_r & ~(s_axi_awvalid & s_axi_awready);
			s_axi_wready <= ~w_have_r & ~(s_axi_wvalid & s_axi_wready);
			s_axi_arready <= ~rvalid_r & ~(s_axi_arvalid & s_axi_arready);
		end
	end

	// ----------------------------------------------------------------
	// Outputs.
	// ----------------------------------------------------------------
	assign pc_load = pc_load_r;
	assign pc_out = pc_out_r;
	assign shadow_restore = restore_r;
	assign status_out = status_out_r;
	assign working_register_out = working_register_out_r;
	assign bank_select_register_out = bsr_out_r;
	assign fault_reset = fault_r;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;

endmodule
`default_nettype wire

// ==== dv/ras_props.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Port checker for the return stack.
// ----------------------------------------
module ras_props (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic core_reset,
	input wire logic call_push,
	input wire logic irq_ack,
	input wire logic irq_high,
	input wire logic push_instr,
	input wire logic return_pop,
	input wire logic pop_instr,
	input wire logic fast_call,
	input wire logic fast_return,
	input wire logic [7:0] status_in,
	input wire logic pc_load,
	input wire ras_pkg::ras_pc_t pc_out,
	input wire logic shadow_restore,
	input wire logic [7:0] status_out,
	input wire logic fault_reset,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	import ras_pkg::*;
	logic [7:0] shd_r;
	logic psh;
	// Any push source this cycle.
	assign psh = call_push | irq_ack | push_instr;
	// Last status value that should sit in the shadow.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			shd_r <= 8'h00;
		end else if (irq_ack | fast_call) begin
			shd_r <= status_in;
		end
	end
	default clocking @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	a_pop_loads_pc: assert property (
		return_pop && !psh && !core_reset |=> pc_load)
		else $error("return pop gave no pc load");
	a_load_has_cause: assert property (
		pc_load |-> $past(return_pop || irq_ack))
		else $error("pc load without a cause");
	a_irq_vector: assert property (
		irq_ack && !core_reset |=>
		pc_out == ($past(irq_high) ? RAS_VEC_HIGH : RAS_VEC_LOW))
		else $error("wrong interrupt vector");
	a_plain_no_load: assert property (
		(pop_instr || push_instr) && !return_pop && !irq_ack |=> !pc_load)
		else $error("push or pop instruction loaded pc");
	a_fast_restore: assert property (
		fast_return && !core_reset |=> shadow_restore)
		else $error("fast return gave no restore");
	a_restore_cause: assert property (
		shadow_restore |-> $past(fast_return))
		else $error("restore without fast return");
	a_shadow_value: assert property (
		shadow_restore |-> status_out == $past(shd_r))
		else $error("restored status differs from shadow");
	a_fault_cause: assert property (
		fault_reset |-> $past(psh || return_pop || pop_instr))
		else $error("fault reset without a stack operation");
	a_read_answer: assert property (
		s_axi_arvalid && s_axi_arready |=>
		s_axi_rvalid && s_axi_rdata[31:8] == 24'h000000)
		else $error("read answer late or upper bits set");
	a_read_hold: assert property (
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped before taken");
	c_fault: cover property (fault_reset);
	c_restore: cover property (shadow_restore);
	c_zero_load: cover property (pc_load && pc_out == RAS_PC_ZERO);
endmodule
bind ras_return_stack ras_props u_props (.aclk(aclk), .aresetn(aresetn),
	.core_reset(core_reset), .call_push(call_push), .irq_ack(irq_ack),
	.irq_high(irq_high), .push_instr(push_instr), .return_pop(return_pop),
	.pop_instr(pop_instr), .fast_call(fast_call), .fast_return(fast_return),
	.status_in(status_in), .pc_load(pc_load), .pc_out(pc_out),
	.shadow_restore(shadow_restore), .status_out(status_out),
	.fault_reset(fault_reset), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
`default_nettype wire

// ==== dv/ras_seq_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Instruction sequencer model: one code bit per strobe.
// ----------------------------------------
module ras_seq_model (
	input wire logic [7:0] op,
	input wire logic irq_off,
	output logic call_push,
	output logic irq_ack,
	output logic irq_high,
	output logic push_instr,
	output logic return_pop,
	output logic pop_instr,
	output logic fast_call,
	output logic fast_return
);
	// Interrupts are held back while software edits the stack top.
	assign irq_ack = op[1] & ~irq_off;
	assign call_push = op[0];
	assign irq_high = op[2];
	assign push_instr = op[3];
	assign return_pop = op[4];
	assign pop_instr = op[5];
	assign fast_call = op[6];
	assign fast_return = op[7];
endmodule
`default_nettype wire

// ==== dv/tb_return_address_stack.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_return_address_stack;
	import ras_pkg::*;
	localparam logic [7:0] CALL = 8'h01;
	localparam logic [7:0] IRQL = 8'h02;
	localparam logic [7:0] IRQH = 8'h06;
	localparam logic [7:0] PUSH = 8'h08;
	localparam logic [7:0] RET = 8'h10;
	localparam logic [7:0] POP = 8'h20;
	localparam logic [7:0] FCALL = 8'h41;
	localparam logic [7:0] FRET = 8'h90;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic core_reset = 1'b0;
	logic irq_off = 1'b0;
	logic [7:0] op = 8'h00;
	logic [7:0] st = 8'h00;
	ras_pc_t pc_in = 21'h000000;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic [31:0] wdata = 32'h00000000;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic arvalid = 1'b0, rready = 1'b0;
	logic call_push, irq_ack, irq_high, push_instr, return_pop;
	logic pop_instr, fast_call, fast_return, pc_load, shadow_restore;
	logic fault_reset, awready, wready, bvalid, arready, rvalid;
	ras_pc_t pc_out;
	logic [7:0] st_out, wr_out, bs_out, o;
	logic [7:0] srcs [4];
	logic [1:0] bresp, rresp, resp;
	logic [31:0] rdata, rd, x;
	logic [31:0] seed = 32'h0000004F;
	ras_pc_t stk [32];
	int error_cnt = 0;
	int checked = 0;
	int cyc = 0;
	ras_seq_model seq_u (.op(op), .irq_off(irq_off), .call_push(call_push),
		.irq_ack(irq_ack), .irq_high(irq_high), .push_instr(push_instr),
		.return_pop(return_pop), .pop_instr(pop_instr),
		.fast_call(fast_call), .fast_return(fast_return));
	ras_return_stack dut_u (.aclk(aclk), .aresetn(aresetn),
		.core_reset(core_reset), .call_push(call_push), .irq_ack(irq_ack),
		.irq_high(irq_high), .push_instr(push_instr), .return_pop(return_pop),
		.pop_instr(pop_instr), .fast_call(fast_call),
		.fast_return(fast_return), .pc_in(pc_in), .status_in(st),
		.working_register_in(st ^ 8'h5A), .bank_select_register_in(st ^ 8'hA5),
		.pc_load(pc_load), .pc_out(pc_out), .shadow_restore(shadow_restore),
		.status_out(st_out), .working_register_out(wr_out),
		.bank_select_register_out(bs_out), .fault_reset(fault_reset),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready));
	// Clock and hang guard.
	initial begin
		forever #5 aclk = ~aclk;
	end
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			error_cnt++;
			report_and_stop();
		end
	end
	// Seeded xorshift source.
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	// Expected status register and restored shadow words.
	function automatic logic [31:0] stat(input logic f, input logic u,
		input logic [4:0] p);
		return {24'h000000, f, u, 1'b0, p};
	endfunction
	function automatic logic [31:0] shd(input logic [7:0] s);
		return {8'h00, s, s ^ 8'h5A, s ^ 8'hA5};
	endfunction
	task automatic cmp(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e) begin
			error_cnt++;
			$display("mismatch at %0t: got %h want %h", $time, g, e);
		end
	endtask
	task automatic cmp_pc(input ras_pc_t e);
		checked++;
		if (pc_load !== 1'b1 || pc_out !== e) begin
			error_cnt++;
			$display("mismatch at %0t: pc %h want %h", $time, pc_out, e);
		end
	endtask
	// Bus master cycles; each channel waits for its own ready.
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		resp = bresp;
		bready <= 1'b0;
	endtask
	task automatic rd_reg(input logic [7:0] a);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		rd = rdata;
		resp = rresp;
		rready <= 1'b0;
	endtask
	task automatic top_chk(input ras_pc_t e);
		rd_reg(RAS_REG_TOP_UPPER);
		cmp(rd, {27'h0000000, e[20:16]});
		rd_reg(RAS_REG_TOP_HIGH);
		cmp(rd, {24'h000000, e[15:8]});
		rd_reg(RAS_REG_TOP_LOW);
		cmp(rd, {24'h000000, e[7:0]});
	endtask
	// One strobe for one cycle, driven on an edge; returns once it settled.
	task automatic seq(input logic [7:0] c, input ras_pc_t p);
		@(posedge aclk);
		op <= c;
		pc_in <= p;
		@(posedge aclk);
		op <= 8'h00;
		#1;
	endtask
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// Main sequence.
	initial begin
		srcs = '{CALL, PUSH, IRQL, IRQH};
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		rd_reg(RAS_REG_PTR_STAT);
		cmp(rd, 32'h00000000);
		rd_reg(RAS_REG_CONFIG);
		cmp(rd, 32'h00000001);
		rd_reg(8'h14);
		cmp({30'h0, resp}, {30'h0, RAS_RESP_SLVERR});
		wr(8'h14, 32'h00000001);
		cmp({30'h0, resp}, {30'h0, RAS_RESP_SLVERR});
		// Random pushes from all sources, discard one, pop the rest.
		for (int i = 1; i <= 12; i++) begin
			x = rnd();
			stk[i] = {x[20:1], 1'b0};
			o = srcs[x[31:30]];
			seq(o, stk[i]);
			if (o[1]) cmp_pc(o[2] ? RAS_VEC_HIGH : RAS_VEC_LOW);
		end
		rd_reg(RAS_REG_PTR_STAT);
		cmp(rd, stat(1'b0, 1'b0, 5'h0C));
		top_chk(stk[12]);
		seq(POP, RAS_PC_ZERO);
		top_chk(stk[11]);
		for (int i = 11; i >= 1; i--) begin
			seq(RET, RAS_PC_ZERO);
			cmp_pc(stk[i]);
		end
		seq(RET, RAS_PC_ZERO);
		cmp_pc(RAS_PC_ZERO);
		cmp({31'h0, fault_reset}, 32'h00000001);
		// Shadow: high priority overwrites low, then fast call.
		x = rnd();
		st <= x[7:0];
		seq(IRQL, RAS_PC_ZERO);
		x = rnd();
		st <= x[7:0];
		seq(IRQH, RAS_PC_ZERO);
		seq(FRET, RAS_PC_ZERO);
		cmp({8'h00, st_out, wr_out, bs_out}, shd(x[7:0]));
		x = rnd();
		st <= x[7:0];
		seq(FCALL, RAS_PC_ZERO);
		seq(FRET, RAS_PC_ZERO);
		cmp({8'h00, st_out, wr_out, bs_out}, shd(x[7:0]));
		// Core reset keeps the flag, zeroes the pointer.
		@(posedge aclk);
		core_reset <= 1'b1;
		@(posedge aclk);
		core_reset <= 1'b0;
		rd_reg(RAS_REG_PTR_STAT);
		cmp(rd, stat(1'b0, 1'b1, 5'h00));
		wr(RAS_REG_PTR_STAT, 32'h00000080);
		cmp({30'h0, resp}, {30'h0, RAS_RESP_OKAY});
		rd_reg(RAS_REG_PTR_STAT);
		cmp(rd, 32'h00000000);
		// Top edit with interrupts held off, then return to it.
		seq(CALL, 21'h000100);
		irq_off <= 1'b1;
		wr(RAS_REG_TOP_UPPER, 32'h00000015);
		wr(RAS_REG_TOP_HIGH, 32'h000000A3);
		wr(RAS_REG_TOP_LOW, 32'h0000005C);
		seq(IRQH, RAS_PC_ZERO);
		seq(RET, RAS_PC_ZERO);
		cmp_pc(21'h15A35C);
		irq_off <= 1'b0;
		// Overflow with fault reset off: pointer sticks at 31.
		wr(RAS_REG_CONFIG, 32'h00000000);
		for (int i = 1; i <= 32; i++) seq(CALL, 21'(i * 4));
		rd_reg(RAS_REG_PTR_STAT);
		cmp(rd, stat(1'b1, 1'b0, 5'h1F));
		top_chk(21'h00007C);
		wr(RAS_REG_PTR_STAT, 32'h00000000);
		// Overflow with fault reset on.
		wr(RAS_REG_CONFIG, 32'h00000001);
		for (int i = 1; i <= 31; i++) seq(CALL, 21'h000200);
		cmp({31'h0, fault_reset}, 32'h00000001);
		rd_reg(RAS_REG_PTR_STAT);
		cmp(rd, stat(1'b1, 1'b0, 5'h00));
		wr(RAS_REG_PTR_STAT, 32'h0000009F);
		top_chk(21'h000200 + RAS_PC_STEP);
		report_and_stop();
	end
endmodule
`default_nettype wire
